// [pwm_cpc_defs.svh]
// constants of the compare, period and interrupt-clear block: bus addresses,
// reset values, interrupt bit positions and the default timer width.
// assumes nothing beyond being included by its bare name.
`ifndef PWM_CPC_DEFS_SVH
`define PWM_CPC_DEFS_SVH

`define PWM_ADDR_A_CMP_C   32'hffff0f8c
`define PWM_ADDR_A_PERIOD  32'hffff0f90
`define PWM_ADDR_B_CMP_C   32'hffff0f9c
`define PWM_ADDR_B_PERIOD  32'h0fff0fa0
`define PWM_ADDR_C_CMP_A   32'hffff0fa4
`define PWM_ADDR_C_CMP_B   32'hffff0fa8
`define PWM_ADDR_C_PERIOD  32'hffff0fb0
`define PWM_ADDR_INT_ACK   32'hffff0fb8
`define PWM_ADDR_INT_STAT  32'hffff0fc0
`define PWM_ADDR_INT_MASK  32'hffff0fc4

`define PWM_RST_CMP        16'h0000
`define PWM_RST_A_PERIOD   16'hffff
`define PWM_RST_B_PERIOD   16'hffff
`define PWM_RST_C_PERIOD   16'h0000
`define PWM_RST_INT_MASK   3'h0

`define PWM_INT_BIT_A      0
`define PWM_INT_BIT_B      1
`define PWM_INT_BIT_C      2
`define PWM_INT_BITS       3
`define PWM_PAIRS          3
`define PWM_TIMER_WIDTH    16

`endif

// [pwm_cpc_pkg.sv]
// types shared by the compare, period and interrupt-clear block.
// assumes pwm_cpc_defs.svh is available on the include path.
`include "pwm_cpc_defs.svh"

package pwm_cpc_pkg;

    typedef logic [`PWM_TIMER_WIDTH-1:0] count_t;

    typedef enum logic [3:0] {
        SEL_NONE      = 4'h0,
        SEL_A_CMP_C   = 4'h1,
        SEL_A_PERIOD  = 4'h2,
        SEL_B_CMP_C   = 4'h3,
        SEL_B_PERIOD  = 4'h4,
        SEL_C_CMP_A   = 4'h5,
        SEL_C_CMP_B   = 4'h6,
        SEL_C_PERIOD  = 4'h7,
        SEL_INT_ACK   = 4'h8,
        SEL_INT_STAT  = 4'h9,
        SEL_INT_MASK  = 4'ha
    } reg_sel_e;

endpackage

// [pwm_pin_drive.sv]
// one modulator output pin: raised on a set hit, dropped on a clear hit.
// assumes both hits come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module pwm_pin_drive (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic set_hit,
    input  wire logic clr_hit,
    output var  logic pin_ff
);

    // clear wins when both compares coincide, so an equal pair gives a low pin
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_ff <= 1'b0;
        end else if (clr_hit) begin
            pin_ff <= 1'b0;
        end else if (set_hit) begin
            pin_ff <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// [pwm_compare_period_clear.sv]
// compare-match, period and interrupt-clear logic of a three-pair modulator,
// with a classic wishbone slave for its registers and one level interrupt.
// assumes a single ref_clk domain and a synchronous active-high reset.
//
// Contract
// - pin one goes low when pair a timer equals pair a compare c
// - pin three goes low when pair b timer equals pair b compare c
// - pin four goes high when pair c timer equals pair c compare a
// - pin four goes low when pair c timer equals pair c compare b
// - pair c period register sets the cycle length of pin four
// - any write to interrupt acknowledge clears the pending interrupt sources
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`include "pwm_cpc_defs.svh"
`default_nettype none

module pwm_compare_period_clear #(
    parameter int TIMER_WIDTH = `PWM_TIMER_WIDTH
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    output var  logic        irq,
    output var  logic        output_pin_one,
    output var  logic        output_pin_three,
    output var  logic        output_pin_four
);

    if (TIMER_WIDTH != `PWM_TIMER_WIDTH) begin : g_width_check
        $error("timer width must match the 16-bit register layout");
    end

    pwm_cpc_pkg::count_t     pair_a_compare_c_ff;
    pwm_cpc_pkg::count_t     pair_a_period_ff;
    pwm_cpc_pkg::count_t     pair_b_compare_c_ff;
    pwm_cpc_pkg::count_t     pair_b_period_ff;
    pwm_cpc_pkg::count_t     pair_c_compare_a_ff;
    pwm_cpc_pkg::count_t     pair_c_compare_b_ff;
    pwm_cpc_pkg::count_t     pair_c_period_ff;
    logic [`PWM_INT_BITS-1:0] int_status_ff;
    logic [`PWM_INT_BITS-1:0] int_mask_ff;
    logic                    ack_ff;
    logic [31:0]             rdata_ff;

    pwm_cpc_pkg::count_t     count_ff   [`PWM_PAIRS];
    pwm_cpc_pkg::count_t     period_val [`PWM_PAIRS];
    pwm_cpc_pkg::count_t     set_val    [`PWM_PAIRS];
    pwm_cpc_pkg::count_t     clr_val    [`PWM_PAIRS];
    logic [`PWM_PAIRS-1:0]   wrap;
    logic [`PWM_PAIRS-1:0]   pin_state;

    pwm_cpc_pkg::reg_sel_e   sel;
    logic                    access;
    logic                    wr_en;
    logic                    ack_wr;
    logic                    stat_wr;
    logic [`PWM_INT_BITS-1:0] nxt_status;
    pwm_cpc_pkg::count_t     rd_val;

    // byte lanes 0 and 1 carry the 16-bit registers
    function automatic pwm_cpc_pkg::count_t merge16(
        input pwm_cpc_pkg::count_t old_val,
        input logic [31:0]         wdata,
        input logic [3:0]          lanes
    );
        pwm_cpc_pkg::count_t res;
        res = old_val;
        if (lanes[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (lanes[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    always_comb begin
        unique case (wb_adr_i)
            `PWM_ADDR_A_CMP_C:  sel = pwm_cpc_pkg::SEL_A_CMP_C;
            `PWM_ADDR_A_PERIOD: sel = pwm_cpc_pkg::SEL_A_PERIOD;
            `PWM_ADDR_B_CMP_C:  sel = pwm_cpc_pkg::SEL_B_CMP_C;
            `PWM_ADDR_B_PERIOD: sel = pwm_cpc_pkg::SEL_B_PERIOD;
            `PWM_ADDR_C_CMP_A:  sel = pwm_cpc_pkg::SEL_C_CMP_A;
            `PWM_ADDR_C_CMP_B:  sel = pwm_cpc_pkg::SEL_C_CMP_B;
            `PWM_ADDR_C_PERIOD: sel = pwm_cpc_pkg::SEL_C_PERIOD;
            `PWM_ADDR_INT_ACK:  sel = pwm_cpc_pkg::SEL_INT_ACK;
            `PWM_ADDR_INT_STAT: sel = pwm_cpc_pkg::SEL_INT_STAT;
            `PWM_ADDR_INT_MASK: sel = pwm_cpc_pkg::SEL_INT_MASK;
            default:            sel = pwm_cpc_pkg::SEL_NONE;
        endcase
    end

    // one access per request; ack drops in the cycle after it was given
    assign access  = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_en   = access && wb_we_i;
    assign ack_wr  = wr_en && (sel == pwm_cpc_pkg::SEL_INT_ACK);
    assign stat_wr = wr_en && (sel == pwm_cpc_pkg::SEL_INT_STAT) && wb_sel_i[0];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= access;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pair_a_compare_c_ff <= `PWM_RST_CMP;
            pair_a_period_ff    <= `PWM_RST_A_PERIOD;
            pair_b_compare_c_ff <= `PWM_RST_CMP;
            pair_b_period_ff    <= `PWM_RST_B_PERIOD;
            pair_c_compare_a_ff <= `PWM_RST_CMP;
            pair_c_compare_b_ff <= `PWM_RST_CMP;
            pair_c_period_ff    <= `PWM_RST_C_PERIOD;
            int_mask_ff         <= `PWM_RST_INT_MASK;
        end else if (wr_en) begin
            unique case (sel)
                pwm_cpc_pkg::SEL_A_CMP_C:  pair_a_compare_c_ff <= merge16(pair_a_compare_c_ff, wb_dat_i, wb_sel_i);
                pwm_cpc_pkg::SEL_A_PERIOD: pair_a_period_ff    <= merge16(pair_a_period_ff, wb_dat_i, wb_sel_i);
                pwm_cpc_pkg::SEL_B_CMP_C:  pair_b_compare_c_ff <= merge16(pair_b_compare_c_ff, wb_dat_i, wb_sel_i);
                pwm_cpc_pkg::SEL_B_PERIOD: pair_b_period_ff    <= merge16(pair_b_period_ff, wb_dat_i, wb_sel_i);
                pwm_cpc_pkg::SEL_C_CMP_A:  pair_c_compare_a_ff <= merge16(pair_c_compare_a_ff, wb_dat_i, wb_sel_i);
                pwm_cpc_pkg::SEL_C_CMP_B:  pair_c_compare_b_ff <= merge16(pair_c_compare_b_ff, wb_dat_i, wb_sel_i);
                pwm_cpc_pkg::SEL_C_PERIOD: pair_c_period_ff    <= merge16(pair_c_period_ff, wb_dat_i, wb_sel_i);
                pwm_cpc_pkg::SEL_INT_MASK: begin
                    if (wb_sel_i[0]) begin
                        int_mask_ff <= wb_dat_i[`PWM_INT_BITS-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // the acknowledge register has no storage and reads as zero
    always_comb begin
        unique case (sel)
            pwm_cpc_pkg::SEL_A_CMP_C:  rd_val = pair_a_compare_c_ff;
            pwm_cpc_pkg::SEL_A_PERIOD: rd_val = pair_a_period_ff;
            pwm_cpc_pkg::SEL_B_CMP_C:  rd_val = pair_b_compare_c_ff;
            pwm_cpc_pkg::SEL_B_PERIOD: rd_val = pair_b_period_ff;
            pwm_cpc_pkg::SEL_C_CMP_A:  rd_val = pair_c_compare_a_ff;
            pwm_cpc_pkg::SEL_C_CMP_B:  rd_val = pair_c_compare_b_ff;
            pwm_cpc_pkg::SEL_C_PERIOD: rd_val = pair_c_period_ff;
            pwm_cpc_pkg::SEL_INT_STAT: rd_val = {13'h0000, int_status_ff};
            pwm_cpc_pkg::SEL_INT_MASK: rd_val = {13'h0000, int_mask_ff};
            default:                   rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_ff <= 32'h0000_0000;
        end else if (access && !wb_we_i) begin
            rdata_ff <= {16'h0000, rd_val};
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // pair c timing comes wholly from its own registers
    assign period_val[0] = pair_a_period_ff;
    assign period_val[1] = pair_b_period_ff;
    assign period_val[2] = pair_c_period_ff;
    assign set_val[0]    = 16'h0000;
    assign set_val[1]    = 16'h0000;
    assign set_val[2]    = pair_c_compare_a_ff;
    assign clr_val[0]    = pair_a_compare_c_ff;
    assign clr_val[1]    = pair_b_compare_c_ff;
    assign clr_val[2]    = pair_c_compare_b_ff;

    generate
        for (genvar i = 0; i < `PWM_PAIRS; i++) begin : g_pair
            // wrap at period
            // wrapping at or above the period keeps a lowered period from a full 16-bit run
            assign wrap[i] = (count_ff[i] >= period_val[i]);

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    count_ff[i] <= 16'h0000;
                end else if (wrap[i]) begin
                    count_ff[i] <= 16'h0000;
                end else begin
                    count_ff[i] <= count_ff[i] + 16'h0001;
                end
            end

            pwm_pin_drive u_pin (
                .ref_clk (ref_clk),
                .reset   (reset),
                .set_hit (count_ff[i] == set_val[i]),
                .clr_hit (count_ff[i] == clr_val[i]),
                .pin_ff  (pin_state[i])
            );
        end
    endgenerate

    assign output_pin_one   = pin_state[0];
    assign output_pin_three = pin_state[1];
    assign output_pin_four  = pin_state[2];

    // acknowledge clears
    // a new wrap in the same cycle as a clear stays pending
    always_comb begin
        nxt_status = int_status_ff;
        if (ack_wr) begin
            nxt_status = '0;
        end else if (stat_wr) begin
            nxt_status = int_status_ff & ~wb_dat_i[`PWM_INT_BITS-1:0];
        end
        nxt_status = nxt_status | wrap;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            int_status_ff <= '0;
        end else begin
            int_status_ff <= nxt_status;
        end
    end

    assign irq = |(int_status_ff & int_mask_ff);

    chk_pin_one_low: assert property (@(posedge ref_clk) disable iff (reset)
        (count_ff[0] == pair_a_compare_c_ff) |=> !output_pin_one)
        else $error("pin one not low after compare c match");

    chk_pin_three_low: assert property (@(posedge ref_clk) disable iff (reset)
        (count_ff[1] == pair_b_compare_c_ff) |=> !output_pin_three)
        else $error("pin three not low after compare c match");

    chk_pin_four_high: assert property (@(posedge ref_clk) disable iff (reset)
        (count_ff[2] == pair_c_compare_a_ff) && (count_ff[2] != pair_c_compare_b_ff) |=> output_pin_four)
        else $error("pin four not high after compare a match");

    chk_pin_four_low: assert property (@(posedge ref_clk) disable iff (reset)
        (count_ff[2] == pair_c_compare_b_ff) |=> !output_pin_four ##1 (output_pin_four == $past(output_pin_four)
        || $past(count_ff[2] == pair_c_compare_a_ff)))
        else $error("pin four not low after compare b match");

    chk_period_wrap: assert property (@(posedge ref_clk) disable iff (reset)
        (count_ff[2] == pair_c_period_ff) |=> (count_ff[2] == 16'h0000))
        else $error("pair c timer did not wrap at its period");

    chk_ack_clears: assert property (@(posedge ref_clk) disable iff (reset)
        ack_wr && (wrap == '0) |=> (int_status_ff == '0) && !irq)
        else $error("acknowledge write did not clear pending interrupt");

    chk_timer_step: assert property (@(posedge ref_clk) disable iff (reset)
        (count_ff[0] < pair_a_period_ff) && $stable(pair_a_period_ff) |=> (count_ff[0] == $past(count_ff[0]) + 16'h0001))
        else $error("pair a timer did not step by one");

    chk_wrap_pair_a: assert property (@(posedge ref_clk) disable iff (reset)
        (count_ff[0] >= pair_a_period_ff) |=> (count_ff[0] == 16'h0000))
        else $error("pair a timer did not wrap at its period");

    chk_period_write: assert property (@(posedge ref_clk) disable iff (reset)
        wr_en && (sel == pwm_cpc_pkg::SEL_C_PERIOD) && (wb_sel_i[1:0] == 2'b11)
        |=> (pair_c_period_ff == $past(wb_dat_i[15:0])))
        else $error("pair c period write did not land");

    chk_wrap_sets_status: assert property (@(posedge ref_clk) disable iff (reset)
        (wrap != '0) |=> ((int_status_ff & $past(wrap)) == $past(wrap)))
        else $error("timer wrap did not set its status bit");

    chk_ack_reads_zero: assert property (@(posedge ref_clk) disable iff (reset)
        access && !wb_we_i && (sel == pwm_cpc_pkg::SEL_INT_ACK) |=> (wb_dat_o == 32'h0000_0000))
        else $error("acknowledge register did not read as zero");

    chk_bus_ack: assert property (@(posedge ref_clk) disable iff (reset)
        access |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");

endmodule

`default_nettype wire

// [pwm_pin_load.sv]
// load model hung on one modulator output pin: counts high cycles and rising edges.
// assumes the pin is sampled on ref_clk and that clear is pulsed by the bench.
`timescale 1ns/100ps
`default_nettype none

module pwm_pin_load (
    input  wire logic        ref_clk,
    input  wire logic        clear,
    input  wire logic        pin,
    output var  logic [15:0] high_cnt_ff,
    output var  logic [15:0] rise_cnt_ff
);
    logic last_ff;

    // counts are only meaningful after the first clear pulse
    always_ff @(posedge ref_clk) begin
        last_ff     <= pin;
        high_cnt_ff <= clear ? 16'h0000 : high_cnt_ff + {15'h0000, pin};
        rise_cnt_ff <= clear ? 16'h0000 : rise_cnt_ff + {15'h0000, pin & ~last_ff};
    end
endmodule

`default_nettype wire

// [pwm_compare_period_clear_bench.sv]
// self-checking bench of the compare, period and interrupt-clear block.
// assumes the design files and pwm_pin_load.sv are compiled before it.
`timescale 1ns/100ps
`include "pwm_cpc_defs.svh"
`default_nettype none

module pwm_compare_period_clear_bench;
    logic        ref_clk  = 1'b0;
    logic        reset    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [31:0] wb_adr_i = 32'h00000000;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        clear    = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq;
    logic [2:0]  pins;
    logic [15:0] high_cnt [3];
    logic [15:0] rise_cnt [3];
    int          n_mismatch = 0;
    int          n_tests    = 0;

    always #20 ref_clk = ~ref_clk;

    pwm_compare_period_clear i_dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq(irq), .output_pin_one(pins[0]), .output_pin_three(pins[1]),
        .output_pin_four(pins[2]));

    for (genvar g = 0; g < 3; g++) begin : g_load
        pwm_pin_load i_load (.ref_clk(ref_clk), .clear(clear), .pin(pins[g]),
                             .high_cnt_ff(high_cnt[g]), .rise_cnt_ff(rise_cnt[g]));
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one classic cycle; the wait is bounded so a dead slave ends the run
    task automatic wb_access(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                             input logic [3:0] sel, output logic [31:0] data);
        int i;
        i = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do begin
            @(posedge ref_clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        data = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH at %0t: no bus answer", $time);
            finish_test();
        end
    endtask

    task automatic wr(input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel = 4'hf);
        logic [31:0] d;
        wb_access(1'b1, adr, dat, sel, d);
    endtask

    task automatic rd_chk(input logic [31:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_access(1'b0, adr, 32'h00000000, 4'hf, d);
        check(d, exp, "read data");
    endtask

    task automatic measure(input int cycles);
        @(posedge ref_clk);
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        repeat (cycles) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_mismatch++;
        $display("MISMATCH at %0t: run limit reached", $time);
        finish_test();
    end

    initial begin
        static logic [31:0] adrs [10] = '{`PWM_ADDR_A_CMP_C, `PWM_ADDR_A_PERIOD, `PWM_ADDR_B_CMP_C, `PWM_ADDR_B_PERIOD,
            `PWM_ADDR_C_CMP_A, `PWM_ADDR_C_CMP_B, `PWM_ADDR_C_PERIOD, `PWM_ADDR_INT_ACK, `PWM_ADDR_INT_MASK,
            32'hffff0f00};
        static logic [15:0] rstv [10] = '{16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000,
            16'h0000, 16'h0000, 16'h0000};
        int p;
        int c;
        int x;
        int y;
        void'($urandom(32'hd6f90232));
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check({28'h0, irq, pins}, 32'h0, "outputs in reset");
        @(posedge ref_clk);
        reset <= 1'b0;
        repeat (10) @(posedge ref_clk);
        // equal set and clear compares keep every pin low
        check({29'h0, pins}, 32'h0, "pins after reset");
        for (int i = 0; i < 10; i++) begin
            rd_chk(adrs[i], {16'h0000, rstv[i]});
        end
        wr(`PWM_ADDR_A_CMP_C, 32'h0000abcd);
        wr(`PWM_ADDR_A_CMP_C, 32'hffff0012, 4'h1);
        rd_chk(`PWM_ADDR_A_CMP_C, 32'h0000ab12);
        $display("test reset values done");

        wr(`PWM_ADDR_C_PERIOD, 32'h0000ffff);
        wr(`PWM_ADDR_INT_STAT, 32'h00000007);
        rd_chk(`PWM_ADDR_INT_STAT, 32'h00000000);
        wr(`PWM_ADDR_C_PERIOD, 32'h00000014);
        repeat (30) @(posedge ref_clk);
        wr(`PWM_ADDR_C_PERIOD, 32'h0000ffff);
        // wrap of pair c with a short period raises its status bit
        rd_chk(`PWM_ADDR_INT_STAT, 32'h00000004);
        check({31'h0, irq}, 32'h0, "irq masked off");
        wr(`PWM_ADDR_INT_MASK, 32'h00000003);
        @(negedge ref_clk);
        check({31'h0, irq}, 32'h0, "irq other bits");
        wr(`PWM_ADDR_INT_MASK, 32'h00000007);
        repeat (10) @(posedge ref_clk);
        // without an acknowledge the interrupt stays up
        check({31'h0, irq}, 32'h1, "irq held");
        wr(`PWM_ADDR_INT_ACK, $urandom);
        @(negedge ref_clk);
        check({31'h0, irq}, 32'h0, "irq after ack");
        rd_chk(`PWM_ADDR_INT_STAT, 32'h00000000);
        $display("test interrupt done");

        for (int k = 0; k < 6; k++) begin
            p = (k == 0) ? 4 : 3 + int'($urandom % 20);
            c = (k == 0) ? 2 : 1 + int'($urandom % (p - 1));
            x = (k == 0) ? 0 : int'($urandom % (p - 1));
            y = (k == 0) ? 4 : x + 1 + int'($urandom % (p - 1 - x));
            wr(`PWM_ADDR_A_CMP_C, 32'(c));
            wr(`PWM_ADDR_B_CMP_C, 32'(c));
            wr(`PWM_ADDR_C_CMP_A, 32'(x));
            wr(`PWM_ADDR_C_CMP_B, 32'(y));
            wr(`PWM_ADDR_A_PERIOD, 32'(p));
            wr(`PWM_ADDR_B_PERIOD, 32'(p));
            wr(`PWM_ADDR_C_PERIOD, 32'(p));
            rd_chk(`PWM_ADDR_C_CMP_B, 32'(y));
            repeat (2 * (p + 1)) @(posedge ref_clk);
            measure(4 * (p + 1));
            check(32'(high_cnt[0]), 32'(4 * c), "pin one high");
            check(32'(high_cnt[1]), 32'(4 * c), "pin three high");
            check(32'(high_cnt[2]), 32'(4 * (y - x)), "pin four high");
            check(32'(rise_cnt[0]), 32'h4, "pin one cycles");
            check(32'(rise_cnt[1]), 32'h4, "pin three cycles");
            check(32'(rise_cnt[2]), 32'h4, "pin four cycles");
        end
        $display("test compare and period done");

        // a reset in mid-run must clear the outputs and restore pair c compare b and pair a period
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        check({28'h0, irq, pins}, 32'h0, "outputs after second reset");
        rd_chk(`PWM_ADDR_C_CMP_B, 32'h00000000);
        rd_chk(`PWM_ADDR_A_PERIOD, {16'h0000, `PWM_RST_A_PERIOD});
        $display("test second reset done");
        finish_test();
    end
endmodule

`default_nettype wire
